// ---- hdl/cam_sim_regs_pkg.sv ----
// Constants shared by the camera simulator host control register bank
package cam_sim_regs_pkg;
  // Register indexes; byte address is four times the index
  localparam int         IDX_LO         = 2;
  localparam int         IDX_W          = 6;
  localparam int         MIN_ADDR_W     = IDX_LO + IDX_W;
  localparam logic [5:0] IDX_COMMAND    = 6'h00;
  localparam logic [5:0] IDX_SER_DATA   = 6'h0A;
  localparam logic [5:0] IDX_SER_STATUS = 6'h0B;
  localparam logic [5:0] IDX_SER_CTRL   = 6'h0C;
  localparam logic [5:0] IDX_SWAP       = 6'h0F;
  localparam logic [5:0] IDX_FRAME_INT  = 6'h10;
  localparam logic [5:0] IDX_SYNTH      = 6'h20;
  localparam logic [5:0] IDX_DIVISOR    = 6'h24;
  localparam logic [5:0] IDX_PIX_FMT    = 6'h28;
  localparam logic [7:0] REG_RESET      = 8'h00;
  // Field positions
  localparam int CTL_RX_EN    = 0;
  localparam int CTL_TX_EN    = 1;
  localparam int CTL_RX_INT   = 2;
  localparam int CTL_TX_INT   = 3;
  localparam int CTL_GLOB     = 4;
  localparam int CTL_RX_CLR   = 5;
  localparam int CTL_BAUD_LO  = 6;
  localparam int SWAP_BYTE    = 0;
  localparam int SWAP_HALF    = 3;
  localparam int FRAME_INT_EN = 3;
  localparam int SYN_CLK      = 7;
  localparam int SYN_DATA     = 6;
  localparam int SYN_LOAD     = 0;
  localparam int PIX_TAPS_LO  = 4;
  localparam int PIX_BITS_LO  = 0;
  localparam int CMD_RST_INTF = 0;
  localparam int CMD_CLR_EDGE = 4;
  localparam int ST_RX_AVAIL  = 0;
  localparam int ST_TX_READY  = 1;
  localparam int ST_EDGE_ACT  = 4;
  localparam int ST_EDGE_LAT  = 6;
  localparam int ST_INT       = 7;
  // Baud timing
  localparam int CLK_HZ     = 100_000_000;
  localparam int REF_HZ     = 20_000_000;
  localparam int OVERSAMPLE = 16;
  localparam int BAUD_0     = 9600;
  localparam int BAUD_1     = 19200;
  localparam int BAUD_2     = 38400;
  localparam int BAUD_3     = 115200;
  localparam logic [15:0] TICKS_0     = 16'(CLK_HZ / (OVERSAMPLE * BAUD_0));
  localparam logic [15:0] TICKS_1     = 16'(CLK_HZ / (OVERSAMPLE * BAUD_1));
  localparam logic [15:0] TICKS_2     = 16'(CLK_HZ / (OVERSAMPLE * BAUD_2));
  localparam logic [15:0] TICKS_3     = 16'(CLK_HZ / (OVERSAMPLE * BAUD_3));
  localparam logic [15:0] DIV_OFFSET  = 16'h0002;
  localparam logic [15:0] CLK_PER_REF = 16'(CLK_HZ / REF_HZ);
  // Character framing, counted in oversample ticks and bits
  localparam logic [3:0] MID_SAMPLE  = 4'h7;
  localparam logic [3:0] LAST_SAMPLE = 4'hF;
  localparam logic [3:0] STOP_BIT    = 4'h9;
  localparam logic [3:0] FRAME_BITS  = 4'hA;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ---- hdl/cam_sim_host_regs.sv ----
// Camera simulator host control registers with serial port and word swap
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module cam_sim_host_regs
  import cam_sim_regs_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output var  logic              awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output var  logic              wready,
  output var  logic [1:0]        bresp,
  output var  logic              bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output var  logic              arready,
  output var  logic [31:0]       rdata,
  output var  logic [1:0]        rresp,
  output var  logic              rvalid,
  input  wire logic              rready,
  output var  logic              serialToGrabber,
  input  wire logic              serialFromGrabber,
  input  wire logic              frameValid,
  input  wire logic [31:0]       pixelDataIn,
  output var  logic [31:0]       pixelDataOut,
  output var  logic              synthClk,
  output var  logic              synthData,
  output var  logic              synthLoad,
  output var  logic [2:0]        tapCountMinusOne,
  output var  logic [3:0]        bitsPerTapMinusOne,
  output var  logic              interfaceIntStatus
);

  if (ADDR_W < MIN_ADDR_W) begin : g_bad_addr
    $error("ADDR_W too narrow for the register map");
  end

  logic              awHave;
  logic              wHave;
  logic [IDX_W-1:0]  wrIdx;
  logic [7:0]        wrByte;
  logic              wrLane;
  logic              doWrite;
  logic              wrHit;
  logic [7:0]        serCtrl;
  logic [7:0]        swapCtrl;
  logic [7:0]        frameIntCtrl;
  logic [7:0]        synthPort;
  logic [7:0]        divisor;
  logic [7:0]        pixFmt;
  logic [IDX_W-1:0]  rdIdx;
  logic [7:0]        rdByte;
  logic              rdHit;
  logic              frameValidPrev;
  logic              frameEdgeLatched;
  logic              frameEdgeActive;
  logic              edgeClear;
  logic [15:0]       tickLimit;
  logic [15:0]       tickCnt;
  logic              tick;
  logic              txHoldFull;
  logic [7:0]        txHold;
  logic              txBusy;
  logic [9:0]        txShift;
  logic [3:0]        txSample;
  logic [3:0]        txBitCnt;
  logic              rxBusy;
  logic [3:0]        rxSample;
  logic [3:0]        rxBitCnt;
  logic [7:0]        rxShift;
  logic [7:0]        rxData;
  logic              rxDone;
  logic              rxAvail;
  logic              rxClear;
  logic              dataWrite;
  logic [31:0]       halfSwapped;

  assign doWrite = awHave && wHave && !bvalid;
  assign rxClear = doWrite && wrLane && wrIdx == IDX_SER_CTRL && wrByte[CTL_RX_CLR];
  assign edgeClear = doWrite && wrLane && wrIdx == IDX_COMMAND
                     && (wrByte[CMD_CLR_EDGE] || wrByte[CMD_RST_INTF]);
  assign dataWrite = doWrite && wrLane && wrIdx == IDX_SER_DATA;

  always_comb begin
    case (wrIdx)
      IDX_COMMAND, IDX_SER_DATA, IDX_SER_STATUS, IDX_SER_CTRL, IDX_SWAP,
      IDX_FRAME_INT, IDX_SYNTH, IDX_DIVISOR, IDX_PIX_FMT: wrHit = 1'b1;
      default: wrHit = 1'b0;
    endcase
  end

  // Write channel: address and data taken in either order, one write at a time
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      awHave  <= 1'b0;
      wHave   <= 1'b0;
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      wrIdx   <= '0;
      wrByte  <= REG_RESET;
      wrLane  <= 1'b0;
    end else begin
      awready <= !awHave && !(awvalid && awready) && !bvalid;
      wready  <= !wHave && !(wvalid && wready) && !bvalid;
      if (awvalid && awready) begin
        awHave <= 1'b1;
        wrIdx  <= awaddr[IDX_LO +: IDX_W];
      end else if (doWrite) begin
        awHave <= 1'b0;
      end
      if (wvalid && wready) begin
        wHave  <= 1'b1;
        wrByte <= wdata[7:0];
        wrLane <= wstrb[0];
      end else if (doWrite) begin
        wHave <= 1'b0;
      end
      if (doWrite) begin
        bvalid <= 1'b1;
        bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      serCtrl      <= REG_RESET;
      swapCtrl     <= REG_RESET;
      frameIntCtrl <= REG_RESET;
      synthPort    <= REG_RESET;
      divisor      <= REG_RESET;
      pixFmt       <= REG_RESET;
    end else if (doWrite && wrLane) begin
      case (wrIdx)
        // clear bit acts once and is not stored
        IDX_SER_CTRL:  serCtrl      <= wrByte & ~(8'h01 << CTL_RX_CLR);
        IDX_SWAP:      swapCtrl     <= wrByte;
        IDX_FRAME_INT: frameIntCtrl <= wrByte;
        IDX_SYNTH:     synthPort    <= wrByte;
        IDX_DIVISOR:   divisor      <= wrByte;
        IDX_PIX_FMT:   pixFmt       <= wrByte;
        default:       ;
      endcase
    end
  end

  assign synthClk  = synthPort[SYN_CLK];
  // serial data line to the synthesizer
  assign synthData = synthPort[SYN_DATA];
  assign synthLoad = synthPort[SYN_LOAD];
  assign tapCountMinusOne   = pixFmt[PIX_TAPS_LO +: 3];
  assign bitsPerTapMinusOne = pixFmt[PIX_BITS_LO +: 4];

  always_comb begin
    rdHit  = 1'b1;
    rdByte = REG_RESET;
    case (rdIdx)
      IDX_COMMAND:    rdByte = REG_RESET;
      IDX_SER_DATA:   rdByte = rxData;
      IDX_SER_STATUS: begin
        rdByte[ST_INT]      = interfaceIntStatus;
        rdByte[ST_EDGE_LAT] = frameEdgeLatched;
        rdByte[ST_EDGE_ACT] = frameEdgeActive;
        rdByte[ST_TX_READY] = !txHoldFull;
        rdByte[ST_RX_AVAIL] = rxAvail;
      end
      IDX_SER_CTRL:   rdByte = serCtrl;
      IDX_SWAP:       rdByte = swapCtrl;
      IDX_FRAME_INT:  rdByte = frameIntCtrl;
      IDX_SYNTH:      rdByte = synthPort;
      IDX_DIVISOR:    rdByte = divisor;
      IDX_PIX_FMT:    rdByte = pixFmt;
      default:        rdHit  = 1'b0;
    endcase
  end

  assign rdIdx = araddr[IDX_LO +: IDX_W];

  // Read channel: data captured on the address handshake, no side effects
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else begin
      arready <= !rvalid && !(arvalid && arready);
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata  <= {24'h000000, rdByte};
        rresp  <= rdHit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  assign halfSwapped = swapCtrl[SWAP_HALF] ? {pixelDataIn[15:0], pixelDataIn[31:16]}
                                           : pixelDataIn;

  // swap bytes inside each half; with this gives full reversal
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pixelDataOut <= '0;
    end else if (swapCtrl[SWAP_BYTE]) begin
      pixelDataOut <= {halfSwapped[23:16], halfSwapped[31:24],
                       halfSwapped[7:0], halfSwapped[15:8]};
    end else begin
      pixelDataOut <= halfSwapped;
    end
  end

  // Edge flag: a new edge in the clearing cycle stays latched
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      frameValidPrev   <= 1'b0;
      frameEdgeLatched <= 1'b0;
    end else begin
      frameValidPrev <= frameValid;
      if (frameValid && !frameValidPrev) begin
        frameEdgeLatched <= 1'b1;
      end else if (edgeClear) begin
        frameEdgeLatched <= 1'b0;
      end
    end
  end

  // active only when latched and enabled; gate
  assign frameEdgeActive = frameEdgeLatched && frameIntCtrl[FRAME_INT_EN];

  // combined interrupt, global gate, source enables
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      interfaceIntStatus <= 1'b0;
    end else begin
      interfaceIntStatus <= serCtrl[CTL_GLOB]
        && (frameEdgeActive
            || (!txHoldFull && serCtrl[CTL_TX_INT])
            || (rxAvail && serCtrl[CTL_RX_INT]));
    end
  end

  // divisor path counts (value + 2) reference periods per tick
  always_comb begin
    if (divisor != REG_RESET) begin
      tickLimit = (16'(divisor) + DIV_OFFSET) * CLK_PER_REF;
    end else begin
      // rate code when divisor is zero
      case (serCtrl[CTL_BAUD_LO +: 2])
        2'b00:   tickLimit = TICKS_0;
        2'b01:   tickLimit = TICKS_1;
        2'b10:   tickLimit = TICKS_2;
        default: tickLimit = TICKS_3;
      endcase
    end
  end

  // oversample tick shared by both directions
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tickCnt <= '0;
      tick    <= 1'b0;
    end else if (tickCnt + 16'h0001 >= tickLimit) begin
      tickCnt <= '0;
      tick    <= 1'b1;
    end else begin
      tickCnt <= tickCnt + 16'h0001;
      tick    <= 1'b0;
    end
  end

  // holding buffer; a write while full is dropped
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txHoldFull <= 1'b0;
      txHold     <= '0;
    end else if (dataWrite && !txHoldFull) begin
      txHoldFull <= 1'b1;
      txHold     <= wrByte;
    end else if (txHoldFull && !txBusy && serCtrl[CTL_TX_EN]) begin
      txHoldFull <= 1'b0;
    end
  end

  // disabling the transmitter aborts and idles the line high
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txBusy          <= 1'b0;
      txShift         <= '1;
      txSample        <= '0;
      txBitCnt        <= '0;
      serialToGrabber <= 1'b1;
    end else if (!serCtrl[CTL_TX_EN]) begin
      txBusy          <= 1'b0;
      serialToGrabber <= 1'b1;
    end else if (!txBusy) begin
      serialToGrabber <= 1'b1;
      if (txHoldFull) begin
        txShift  <= {1'b1, txHold, 1'b0};
        txBusy   <= 1'b1;
        txSample <= '0;
        txBitCnt <= '0;
      end
    end else begin
      serialToGrabber <= txShift[0];
      if (tick) begin
        txSample <= txSample + 4'h1;
        if (txSample == LAST_SAMPLE) begin
          txShift  <= {1'b1, txShift[9:1]};
          txBitCnt <= txBitCnt + 4'h1;
          if (txBitCnt + 4'h1 == FRAME_BITS) begin
            txBusy <= 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rxBusy   <= 1'b0;
      rxSample <= '0;
      rxBitCnt <= '0;
      rxShift  <= '0;
      rxData   <= '0;
      rxDone   <= 1'b0;
    end else begin
      rxDone <= 1'b0;
      if (!serCtrl[CTL_RX_EN]) begin
        rxBusy <= 1'b0;
      end else if (tick && !rxBusy) begin
        if (!serialFromGrabber) begin
          rxBusy   <= 1'b1;
          rxSample <= '0;
          rxBitCnt <= '0;
        end
      end else if (tick) begin
        rxSample <= rxSample + 4'h1;
        if (rxSample == MID_SAMPLE) begin
          rxBitCnt <= rxBitCnt + 4'h1;
          if (rxBitCnt == '0 && serialFromGrabber) begin
            // Glitch shorter than half a bit is not a start bit
            rxBusy <= 1'b0;
          end else if (rxBitCnt == STOP_BIT) begin
            rxBusy <= 1'b0;
            if (serialFromGrabber) begin
              rxData <= rxShift;
              rxDone <= 1'b1;
            end
          end else if (rxBitCnt != '0) begin
            rxShift <= {serialFromGrabber, rxShift[7:1]};
          end
        end
      end
    end
  end

  // a character finishing in the clearing cycle keeps the flag set
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rxAvail <= 1'b0;
    end else if (rxDone) begin
      rxAvail <= 1'b1;
    end else if (rxClear) begin
      rxAvail <= 1'b0;
    end
  end

  a_code_rate: assert property (@(posedge clk) disable iff (!rst_b)
    divisor == REG_RESET |-> tickLimit == (serCtrl[7:6] == 2'b00 ? 16'h028B
                                         : serCtrl[7:6] == 2'b01 ? 16'h0145
                                         : serCtrl[7:6] == 2'b10 ? 16'h00A2 : 16'h0036))
    else $error("zero divisor does not follow the rate code");

  a_divisor_rate: assert property (@(posedge clk) disable iff (!rst_b)
    divisor == 8'h02 |-> tickLimit == 16'h0014)
    else $error("divisor 2 does not give 4 reference periods per tick");

  a_rx_clear: assert property (@(posedge clk) disable iff (!rst_b)
    rxClear && !rxDone |=> !rxAvail)
    else $error("receive flag not cleared by control write");

  a_global_gate: assert property (@(posedge clk) disable iff (!rst_b)
    !serCtrl[CTL_GLOB] |=> !interfaceIntStatus)
    else $error("interrupt raised with global enable off");

  a_tx_int: assert property (@(posedge clk) disable iff (!rst_b)
    serCtrl[CTL_GLOB] && serCtrl[CTL_TX_INT] && !txHoldFull |=> interfaceIntStatus)
    else $error("transmit-empty interrupt missing");

  a_rx_int: assert property (@(posedge clk) disable iff (!rst_b)
    serCtrl[CTL_GLOB] && serCtrl[CTL_RX_INT] && rxAvail |=> interfaceIntStatus)
    else $error("receive interrupt missing");

  a_tx_idle: assert property (@(posedge clk) disable iff (!rst_b)
    !serCtrl[CTL_TX_EN] |=> serialToGrabber && !txBusy)
    else $error("transmitter active while disabled");

  a_rx_idle: assert property (@(posedge clk) disable iff (!rst_b)
    !serCtrl[CTL_RX_EN] |=> !rxDone)
    else $error("character received while receiver disabled");

  a_full_swap: assert property (@(posedge clk) disable iff (!rst_b)
    swapCtrl[SWAP_HALF] && swapCtrl[SWAP_BYTE] |=> pixelDataOut ==
      {$past(pixelDataIn[7:0]), $past(pixelDataIn[15:8]),
       $past(pixelDataIn[23:16]), $past(pixelDataIn[31:24])})
    else $error("both swaps do not reverse bytes");

  a_edge_gate: assert property (@(posedge clk) disable iff (!rst_b)
    !frameIntCtrl[FRAME_INT_EN] && !serCtrl[CTL_TX_INT] && !serCtrl[CTL_RX_INT]
    |=> !interfaceIntStatus)
    else $error("frame edge reaches the interrupt with its enable clear");

endmodule // cam_sim_host_regs
`default_nettype wire

// ---- test/grabber_uart_model.sv ----
// Frame grabber end of the serial link: receives and sends characters
`timescale 1ns/100ps
`default_nettype none
module grabber_uart_model (
  input  wire logic clk,
  input  var  int   bitClks,
  input  wire logic txLine,
  output var  logic rxLine
);
  logic [7:0] gotByte;
  int         gotCount;

  initial begin
    rxLine   = 1'b1;
    gotByte  = 8'h00;
    gotCount = 0;
  end

  // start bit, eight data bits LSB first, sampled mid-bit
  always begin
    @(negedge txLine);
    repeat (bitClks + bitClks / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      gotByte[i] = txLine;
      repeat (bitClks) @(posedge clk);
    end
    gotCount++;
  end

  // one start bit, no parity, two stop bits toward the device
  task automatic sendByte(input logic [7:0] b);
    rxLine <= 1'b0;
    repeat (bitClks) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      rxLine <= b[i];
      repeat (bitClks) @(posedge clk);
    end
    rxLine <= 1'b1;
    repeat (2 * bitClks) @(posedge clk);
  endtask
endmodule // grabber_uart_model
`default_nettype wire

// ---- test/tb_camera_sim_host_control_regs.sv ----
// Self-checking bench for the host control register bank
`timescale 1ns/100ps
`default_nettype none
`define CHECK(a, b) begin checked++; if ((a) !== (b)) begin errorCnt++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_camera_sim_host_control_regs;
  import cam_sim_regs_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, pixelDataIn = 32'h0, pixelDataOut, rdata;
  logic [3:0] wstrb = 4'hF, bitsPerTapMinusOne;
  logic awready, wready, bvalid, arready, rvalid, serialToGrabber, serialFromGrabber;
  logic frameValid = 1'b0, synthClk, synthData, synthLoad, interfaceIntStatus;
  logic [1:0] bresp, rresp, resp;
  logic [2:0] tapCountMinusOne;
  logic [7:0] rd, v;
  logic [31:0] seed = 32'h725D;
  int errorCnt = 0, checked = 0, cycles = 0, bitClks = 864, prev;
  localparam logic [5:0] RW_IDX [5] = '{IDX_SWAP, IDX_FRAME_INT, IDX_SYNTH, IDX_DIVISOR,
                                       IDX_PIX_FMT};

  always #5 clk = ~clk;

  cam_sim_host_regs dut (.clk(clk), .rst_b(rst_b), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .serialToGrabber(serialToGrabber), .serialFromGrabber(serialFromGrabber),
    .frameValid(frameValid), .pixelDataIn(pixelDataIn), .pixelDataOut(pixelDataOut),
    .synthClk(synthClk), .synthData(synthData), .synthLoad(synthLoad),
    .tapCountMinusOne(tapCountMinusOne), .bitsPerTapMinusOne(bitsPerTapMinusOne),
    .interfaceIntStatus(interfaceIntStatus));

  grabber_uart_model partner (.clk(clk), .bitClks(bitClks), .txLine(serialToGrabber),
    .rxLine(serialFromGrabber));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] expSwap(input logic [31:0] d, input logic [1:0] m);
    logic [31:0] t;
    t = m[0] ? {d[23:16], d[31:24], d[7:0], d[15:8]} : d;
    return m[1] ? {t[15:0], t[31:16]} : t;
  endfunction

  task automatic wr(input logic [5:0] idx, input logic [7:0] val);
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'(xs() >> 8), val};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Only the bench timeout ends a wait for the answer
    forever begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        resp = bresp;
        break;
      end
    end
    bready <= 1'b0;
  endtask

  task automatic rdReg(input logic [5:0] idx);
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        rd = rdata[7:0];
        resp = rresp;
        break;
      end
    end
    rready <= 1'b0;
  endtask

  task automatic waitChar();
    for (int n = 0; n < 20000 && partner.gotCount == prev; n++) @(posedge clk);
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checked, errorCnt);
    if (errorCnt == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Ceiling well above the slowest character traffic in the run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      errorCnt++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    rdReg(IDX_SER_CTRL); `CHECK(rd, REG_RESET)
    foreach (RW_IDX[i]) begin
      rdReg(RW_IDX[i]); `CHECK(rd, REG_RESET)
    end
    rdReg(6'h3F); `CHECK({resp, rd}, {RESP_SLVERR, 8'h00})
    for (int i = 0; i < 10; i++) begin
      v = 8'(xs());
      wr(RW_IDX[i % 5], v);
      rdReg(RW_IDX[i % 5]); `CHECK(rd, v)
      if (RW_IDX[i % 5] == IDX_SYNTH) begin
        `CHECK({synthClk, synthData, synthLoad}, {v[7], v[6], v[0]})
      end
      if (RW_IDX[i % 5] == IDX_PIX_FMT) begin
        `CHECK({tapCountMinusOne, bitsPerTapMinusOne}, v[6:0])
      end
    end
    // Every swap mode, including both at once
    for (int m = 0; m < 8; m++) begin
      wr(IDX_SWAP, {4'h0, m[1], 2'b00, m[0]});
      pixelDataIn <= xs();
      @(posedge clk);
      @(posedge clk);
      #1 `CHECK(pixelDataOut, expSwap(pixelDataIn, m[1:0]))
    end
    wr(IDX_SER_CTRL, 8'h10);
    wr(IDX_FRAME_INT, 8'h00);
    frameValid <= 1'b1;
    repeat (3) @(posedge clk);
    rdReg(IDX_SER_STATUS); `CHECK(rd & 8'hD1, 8'h40)
    wr(IDX_FRAME_INT, 8'h08);
    rdReg(IDX_SER_STATUS); `CHECK(rd & 8'hD1, 8'hD0)
    wr(IDX_SER_CTRL, 8'h00);
    // Interrupt is registered one cycle after the control write lands
    @(posedge clk);
    `CHECK(interfaceIntStatus, 1'b0)
    wr(IDX_COMMAND, 8'h10);
    frameValid <= 1'b0;
    rdReg(IDX_SER_STATUS); `CHECK(rd & 8'h50, 8'h00)
    // Interface reset command clears the latch as well
    frameValid <= 1'b1;
    repeat (3) @(posedge clk);
    rdReg(IDX_SER_STATUS); `CHECK(rd[ST_EDGE_LAT], 1'b1)
    wr(IDX_COMMAND, 8'h01);
    frameValid <= 1'b0;
    rdReg(IDX_SER_STATUS); `CHECK(rd & 8'h50, 8'h00)
    // Rate code 11 with transmit interrupt, then divisor 2 with global enable off
    wr(IDX_DIVISOR, 8'h00);
    // codes 01 and 10 reach the rate assertion
    wr(IDX_SER_CTRL, 8'h40);
    wr(IDX_SER_CTRL, 8'h80);
    wr(IDX_SER_CTRL, 8'hDA);
    // code 11 gives 54 clocks per tick
    bitClks = 54 * 16;
    v = 8'(xs());
    prev = partner.gotCount;
    wr(IDX_SER_DATA, v);
    waitChar();
    `CHECK(partner.gotByte, v)
    `CHECK(interfaceIntStatus, 1'b1)
    wr(IDX_DIVISOR, 8'h02);
    wr(IDX_SER_CTRL, 8'h0A);
    // divisor d gives (d+2) reference periods per tick
    bitClks = (2 + 2) * 5 * 16;
    v = 8'(xs());
    prev = partner.gotCount;
    wr(IDX_SER_DATA, v);
    waitChar();
    `CHECK(partner.gotByte, v)
    `CHECK(interfaceIntStatus, 1'b0)
    // Receive path with its interrupt, clear, then receiver disabled
    wr(IDX_SER_CTRL, 8'h15);
    v = 8'(xs());
    partner.sendByte(v);
    rdReg(IDX_SER_STATUS); `CHECK(rd[ST_RX_AVAIL], 1'b1)
    `CHECK(interfaceIntStatus, 1'b1)
    rdReg(IDX_SER_DATA); `CHECK(rd, v)
    wr(IDX_SER_CTRL, 8'h35);
    rdReg(IDX_SER_STATUS); `CHECK(rd[ST_RX_AVAIL], 1'b0)
    wr(IDX_SER_CTRL, 8'h14);
    partner.sendByte(8'(xs()));
    rdReg(IDX_SER_STATUS); `CHECK(rd[ST_RX_AVAIL], 1'b0)
    // Transmitter disabled keeps the line idle
    prev = partner.gotCount;
    wr(IDX_SER_DATA, 8'h00);
    repeat (3 * bitClks) @(posedge clk);
    `CHECK(partner.gotCount, prev)
    `CHECK(serialToGrabber, 1'b1)
    tally_and_finish();
  end
endmodule // tb_camera_sim_host_control_regs
`default_nettype wire
